// [rtl/asp_defs.vh]
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASP_OFF_STATUS 8'h00
`define ASP_OFF_DATA 8'h04
`define ASP_OFF_CONFIG 8'h08
`define ASP_OFF_CONTROL 8'h0c
// ----------------------------------------
// rx_tx_status bit positions
// ----------------------------------------
`define ASP_ST_TX_EMPTY 7
`define ASP_ST_TX_DONE 6
`define ASP_ST_RX_FULL 5
`define ASP_ST_QUIET 4
`define ASP_ST_OVERRUN 3
`define ASP_ST_NOISE 2
`define ASP_ST_FRAMING 1
`define ASP_ST_PARITY 0
// ----------------------------------------
// line_config bit positions
// ----------------------------------------
`define ASP_CF_RX_NINTH 7
`define ASP_CF_TX_NINTH 6
`define ASP_CF_SERIAL_OFF 5
`define ASP_CF_WORD_LEN 4
`define ASP_CF_ROUSE 3
`define ASP_CF_PARITY_ON 2
`define ASP_CF_PARITY_ODD 1
`define ASP_CF_PARITY_IRQ 0
// ----------------------------------------
// line_control bit positions
// ----------------------------------------
`define ASP_CT_TX_EMPTY_IRQ 7
`define ASP_CT_TX_DONE_IRQ 6
`define ASP_CT_RX_IRQ 5
`define ASP_CT_QUIET_IRQ 4
`define ASP_CT_TX_ON 3
`define ASP_CT_RX_ON 2
`define ASP_CT_MUTE 1
`define ASP_CT_BREAK 0
// ----------------------------------------
// reset values, bus answers, timing
// ----------------------------------------
`define ASP_RST_STATUS 8'hc0
`define ASP_RST_CONFIG 8'h00
`define ASP_RST_CONTROL 8'h00
`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2
`define ASP_SAMPLES 16
`define ASP_SAMPLE_FIRST 4'h7
`define ASP_SAMPLE_LAST 4'hf
`define ASP_FRAME_SHORT 4'ha
`define ASP_FRAME_LONG 4'hb
`define ASP_TICK_DIV 16'h0036
`endif

// [rtl/asp_rx_sampler.v]
`timescale 1ns/1ps
`default_nettype none
`include "asp_defs.vh"
// ----------------------------------------
// per-bit sampler: majority of three middle samples
// ----------------------------------------
module asp_rx_sampler (
  input wire clock,
  input wire reset,
  input wire ce,
  input wire restart,
  input wire tick,
  input wire line,
  output reg bit_val,
  output reg noise,
  output reg done
);
  reg [3:0] cnt_q; // sample index within the bit
  reg [2:0] smp_q; // samples 7, 8 and 9

  // sixteen samples per bit, decide at the last one
  always @(posedge clock) begin
    if (reset) begin
      cnt_q <= 4'h0;
      smp_q <= 3'h0;
      bit_val <= 1'b1;
      noise <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (restart) begin
        cnt_q <= 4'h0;
      end else if (tick) begin
        cnt_q <= cnt_q + 4'h1;
        // keep the middle samples
        if (cnt_q >= `ASP_SAMPLE_FIRST && cnt_q <= `ASP_SAMPLE_FIRST + 4'h2) begin
          smp_q <= {smp_q[1:0], line};
        end
        // last sample: majority vote and disagreement
        if (cnt_q == `ASP_SAMPLE_LAST) begin
          bit_val <= (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
          noise <= !((smp_q == 3'h0) || (smp_q == 3'h7));
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/asp_tick.v]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sixteen-times-bit-rate tick generator
// ----------------------------------------
module asp_tick #(
  parameter [15:0] DIV = 16'h0036
) (
  input wire clock,
  input wire reset,
  input wire ce,
  input wire run,
  output reg tick
);
  reg [15:0] cnt_q; // cycles since last tick

  // count up to the divider, one tick per wrap; frozen when not running
  always @(posedge clock) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        tick <= 1'b0;
      end else if (cnt_q >= DIV - 16'h0001) begin
        cnt_q <= 16'h0000;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/asp_top.v]
// Behaviour
// - tx empty set on shift load, sequence clears
// - no shift load while tx empty set
// - tx done after data frames only
// - rx full set on holding load
// - quiet line flag rearmed by rx full
// - overrun keeps holding, drops new word
// - noise flag, no own interrupt
// - framing flag; overrun alone wins together
// - parity error flag with own enable
// - ninth bit stored and transmitted
// - serial off stops ticks after byte
// - word length eight or nine bits
// - wake on idle or address mark
// - parity in most significant bit
// - even or odd parity selection
// - tx on pulse during a frame sends one preamble
// - one bit delay after tx on
// - tx pin released when both off
// - rx on enables start bit hunt
// - mute mode cleared by wake-up
// - break characters while break set
// - data address splits tx and rx
// - sixteen samples, majority, noise
`timescale 1ns/1ps
`default_nettype none
`include "asp_defs.vh"
module asp_top #(
  parameter [15:0] TICK_DIV = `ASP_TICK_DIV
) (
  input wire clock,
  input wire reset,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_pin,
  output reg tx_pin,
  output reg tx_pin_oe_n,
  output reg irq
);
  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam [1:0] TX_OFF = 2'h0, TX_WAIT = 2'h1, TX_READY = 2'h2, TX_SEND = 2'h3;
  localparam [1:0] RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h2, RX_STOP = 2'h3;
  localparam [1:0] K_DATA = 2'h0, K_BREAK = 2'h1, K_PRE = 2'h2;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [7:0] cfg_q; // line_config, bit 7 unused here
  reg [7:0] ctl_q; // line_control
  reg rx_ninth_q; // received ninth bit
  reg [7:0] tx_holding_q; // written side of char_buffer
  reg [7:0] rx_holding_q; // read side of char_buffer
  reg tx_empty_q, tx_done_q, rx_full_q, quiet_q;
  reg overrun_q, noise_q, framing_q, parity_q;
  reg status_seen_q; // status accessed since last data access
  reg aw_have_q, w_have_q; // write halves captured
  reg [7:0] aw_addr_q;
  reg [7:0] w_data_q;
  reg w_strb_q;
  reg [31:0] rd_word; // read mux
  reg rd_ok; // mapped read address
  reg tx_on_prev_q, brk_prev_q, tx_ever_q;
  reg pre_pend_q, brk_pend_q; // queued preamble and break
  reg [1:0] tx_st_q, tx_kind_q;
  reg [3:0] tx_sub_q, tx_cnt_q;
  reg [10:0] tx_sh_q;
  reg rx_s1_q, rx_s2_q; // pin synchroniser
  reg [1:0] rx_st_q;
  reg [3:0] rx_cnt_q;
  reg [8:0] rx_sh_q;
  reg rx_noise_q, rx_wl_q;
  reg [7:0] idle_cnt_q; // ticks of high line
  reg quiet_arm_q; // quiet flag may be set
  reg [8:0] rx_word; // aligned received word
  reg [8:0] tx_bits; // data bits to send
  wire tick, smp_bit, smp_noise, smp_done;
  wire wl = cfg_q[`ASP_CF_WORD_LEN];
  wire par_on = cfg_q[`ASP_CF_PARITY_ON];
  wire par_odd = cfg_q[`ASP_CF_PARITY_ODD];
  wire tx_on = ctl_q[`ASP_CT_TX_ON];
  wire rx_on = ctl_q[`ASP_CT_RX_ON];
  wire mute = ctl_q[`ASP_CT_MUTE];
  wire [3:0] frame_len = wl ? `ASP_FRAME_LONG : `ASP_FRAME_SHORT;
  wire [7:0] idle_lim = {frame_len, 4'h0};
  wire [7:0] status = {tx_empty_q, tx_done_q, rx_full_q, quiet_q, overrun_q, noise_q, framing_q, parity_q};
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rd_status = rd_fire && (s_axi_araddr == `ASP_OFF_STATUS);
  wire rd_data = rd_fire && (s_axi_araddr == `ASP_OFF_DATA);
  wire wr_en = wr_fire && w_strb_q;
  wire wr_data = wr_en && (aw_addr_q == `ASP_OFF_DATA);
  wire clr_rx = rd_data && status_seen_q;
  wire clr_tx = wr_data && status_seen_q;
  wire bit_end = tick && (tx_sub_q == `ASP_SAMPLE_LAST);
  wire tx_load = (tx_st_q == TX_READY) && tx_on;
  wire send_brk = ctl_q[`ASP_CT_BREAK] || brk_pend_q;
  wire send_data = !send_brk && !pre_pend_q && !tx_empty_q;
  wire idle_hit = (rx_st_q == RX_IDLE) && rx_on && rx_s2_q && tick && (idle_cnt_q == idle_lim - 8'h01);
  wire stop_done = (rx_st_q == RX_STOP) && smp_done;
  wire rx_msb = rx_wl_q ? rx_word[8] : rx_word[7];
  wire addr_wake = stop_done && mute && cfg_q[`ASP_CF_ROUSE] && rx_msb;
  wire idle_wake = idle_hit && mute && !cfg_q[`ASP_CF_ROUSE];
  wire deliver = stop_done && (!mute || addr_wake);
  wire rx_par_err = par_on && ((rx_wl_q ? ^rx_word : ^rx_word[7:0]) ^ par_odd);
  wire set_full = deliver && !rx_full_q;
  wire set_ovr = deliver && rx_full_q;
  wire running = !cfg_q[`ASP_CF_SERIAL_OFF] || (tx_st_q == TX_SEND) || (rx_st_q != RX_IDLE);

  // ----------------------------------------
  // sub-blocks
  // ----------------------------------------
  asp_tick #(.DIV(TICK_DIV)) u_tick (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .run(running),
    .tick(tick)
  );

  asp_rx_sampler u_smp (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .restart((rx_st_q == RX_IDLE) && rx_on && !rx_s2_q),
    .tick(tick),
    .line(rx_s2_q),
    .bit_val(smp_bit),
    .noise(smp_noise),
    .done(smp_done)
  );

  // ----------------------------------------
  // bus read mux and word formatting
  // ----------------------------------------
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `ASP_OFF_STATUS: rd_word = {24'h000000, status};
      `ASP_OFF_DATA: rd_word = {24'h000000, rx_holding_q};
      `ASP_OFF_CONFIG: rd_word = {24'h000000, rx_ninth_q, cfg_q[6:0]};
      `ASP_OFF_CONTROL: rd_word = {24'h000000, ctl_q};
      default: begin
        rd_word = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
    // align received word; eight-bit words sit in the upper shift bits
    rx_word = rx_wl_q ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    // parity replaces the top bit of the word
    if (wl) begin
      tx_bits = {par_on ? (^tx_holding_q ^ par_odd) : cfg_q[`ASP_CF_TX_NINTH], tx_holding_q};
    end else begin
      tx_bits = {1'b1, par_on ? (^tx_holding_q[6:0] ^ par_odd) : tx_holding_q[7], tx_holding_q[6:0]};
    end
  end

  // ----------------------------------------
  // axi4-lite slave handshakes
  // ----------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASP_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ASP_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (ce) begin
      // capture address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      // both halves present: perform and answer
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q[7:4] == 4'h0 && aw_addr_q[1:0] == 2'h0) ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // read: one at a time
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      cfg_q <= `ASP_RST_CONFIG;
      ctl_q <= `ASP_RST_CONTROL;
      tx_holding_q <= 8'h00;
      status_seen_q <= 1'b0;
    end else if (ce) begin
      // status access arms, data access consumes
      if (rd_data || wr_data) begin
        status_seen_q <= 1'b0;
      end else if (rd_status || (wr_en && aw_addr_q == `ASP_OFF_STATUS)) begin
        status_seen_q <= 1'b1;
      end
      // wake-up sequence clears mute; a later write may set it again
      if (addr_wake || idle_wake) begin
        ctl_q[`ASP_CT_MUTE] <= 1'b0;
      end
      if (wr_data) begin
        tx_holding_q <= w_data_q;
      end
      if (wr_en && aw_addr_q == `ASP_OFF_CONFIG) begin
        cfg_q <= {1'b0, w_data_q[6:0]};
      end
      if (wr_en && aw_addr_q == `ASP_OFF_CONTROL) begin
        ctl_q <= w_data_q;
      end
    end
  end

  // ----------------------------------------
  // status flags: set wins over clear
  // ----------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      {tx_empty_q, tx_done_q, rx_full_q, quiet_q, overrun_q, noise_q, framing_q, parity_q} <= `ASP_RST_STATUS;
      quiet_arm_q <= 1'b0;
      rx_holding_q <= 8'h00;
      rx_ninth_q <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      tx_empty_q <= (tx_load && send_data) || (tx_empty_q && !clr_tx);
      tx_done_q <= (tx_st_q == TX_SEND && bit_end && tx_cnt_q == 4'h1 && tx_kind_q == K_DATA)
        || (tx_done_q && !clr_tx);
      rx_full_q <= set_full || (rx_full_q && !clr_rx);
      overrun_q <= set_ovr || (overrun_q && !clr_rx);
      noise_q <= (set_full && (rx_noise_q || smp_noise)) || (noise_q && !clr_rx);
      framing_q <= (set_full && !smp_bit) || (framing_q && !clr_rx);
      parity_q <= (set_full && rx_par_err) || (parity_q && !clr_rx);
      quiet_q <= (idle_hit && !mute && quiet_arm_q) || (quiet_q && !clr_rx);
      // rearm quiet detection only once a word has arrived
      if (set_full) begin
        quiet_arm_q <= 1'b1;
      end else if (idle_hit && !mute) begin
        quiet_arm_q <= 1'b0;
      end
      // holding register kept on overrun
      if (set_full) begin
        rx_holding_q <= rx_word[7:0];
        if (rx_wl_q) begin
          rx_ninth_q <= rx_word[8];
        end
      end
      irq <= (tx_empty_q && ctl_q[`ASP_CT_TX_EMPTY_IRQ]) || (tx_done_q && ctl_q[`ASP_CT_TX_DONE_IRQ])
        || ((rx_full_q || overrun_q) && ctl_q[`ASP_CT_RX_IRQ]) || (quiet_q && ctl_q[`ASP_CT_QUIET_IRQ])
        || (parity_q && cfg_q[`ASP_CF_PARITY_IRQ]);
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      tx_st_q <= TX_OFF;
      tx_kind_q <= K_DATA;
      tx_sub_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      tx_pin <= 1'b1;
      tx_pin_oe_n <= 1'b1;
      tx_on_prev_q <= 1'b0;
      brk_prev_q <= 1'b0;
      tx_ever_q <= 1'b0;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else if (ce) begin
      tx_on_prev_q <= tx_on;
      brk_prev_q <= ctl_q[`ASP_CT_BREAK];
      if (tx_on) begin
        tx_ever_q <= 1'b1;
      end
      // pin released when both directions are off or tx on has never been set
      tx_pin_oe_n <= (!tx_on && !rx_on) || !tx_ever_q;
      // falling break bit queues one break word
      if (brk_prev_q && !ctl_q[`ASP_CT_BREAK]) begin
        brk_pend_q <= 1'b1;
      end
      // tx on pulse during a frame queues a preamble
      if (tx_on && !tx_on_prev_q && tx_st_q == TX_SEND) begin
        pre_pend_q <= 1'b1;
      end
      if (tick) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      case (tx_st_q)
        TX_OFF: begin
          tx_pin <= 1'b1;
          if (tx_on) begin
            tx_st_q <= TX_WAIT;
            tx_sub_q <= 4'h0;
          end
        end
        TX_WAIT: begin
          if (bit_end) begin
            tx_st_q <= TX_READY;
          end
        end
        TX_READY: begin
          if (!tx_on) begin
            tx_st_q <= TX_OFF;
          end else if (send_brk || pre_pend_q || send_data) begin
            tx_st_q <= TX_SEND;
            tx_sub_q <= 4'h0;
            tx_cnt_q <= frame_len;
            if (send_brk) begin
              tx_kind_q <= K_BREAK;
              tx_sh_q <= 11'h000;
              tx_pin <= 1'b0;
              brk_pend_q <= 1'b0;
            end else if (pre_pend_q) begin
              tx_kind_q <= K_PRE;
              tx_sh_q <= 11'h7ff;
              tx_pin <= 1'b1;
              pre_pend_q <= 1'b0;
            end else begin
              tx_kind_q <= K_DATA;
              tx_sh_q <= {1'b1, tx_bits, 1'b0};
              tx_pin <= 1'b0;
            end
          end
        end
        TX_SEND: begin
          if (bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
            tx_pin <= (tx_cnt_q == 4'h1) ? 1'b1 : tx_sh_q[1];
            if (tx_cnt_q == 4'h1) begin
              tx_st_q <= tx_on ? TX_READY : TX_OFF;
            end
          end
        end
        default: tx_st_q <= TX_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_noise_q <= 1'b0;
      rx_wl_q <= 1'b0;
      idle_cnt_q <= 8'h00;
    end else if (ce) begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      // count high line while idle; saturate after one frame
      if (rx_st_q != RX_IDLE || !rx_s2_q || !rx_on) begin
        idle_cnt_q <= 8'h00;
      end else if (tick && idle_cnt_q != idle_lim) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_on && !rx_s2_q) begin
            rx_st_q <= RX_START;
            rx_wl_q <= wl;
          end
        end
        RX_START: begin
          if (smp_done) begin
            rx_st_q <= smp_bit ? RX_IDLE : RX_DATA;
            rx_noise_q <= smp_noise;
            rx_cnt_q <= rx_wl_q ? 4'h9 : 4'h8;
          end
        end
        RX_DATA: begin
          if (smp_done) begin
            rx_sh_q <= {smp_bit, rx_sh_q[8:1]};
            rx_noise_q <= rx_noise_q || smp_noise;
            rx_cnt_q <= rx_cnt_q - 4'h1;
            if (rx_cnt_q == 4'h1) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (smp_done) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
      if (!rx_on) begin
        rx_st_q <= RX_IDLE;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/asp_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// bus answer and line checks
// ----
module asp_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_pin,
  input wire logic tx_pin_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // both write halves taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // start bit driven by the block
  sequence start_low;
    $fell(tx_pin) ##0 !tx_pin_oe_n;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_released_idle: assert property (tx_pin_oe_n |-> tx_pin)
    else $error("released pin not high");
  a_start_len: assert property (start_low |-> !tx_pin [*8])
    else $error("start bit too short");
endmodule
bind asp_top asp_monitor mon_u (.clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_pin, .tx_pin_oe_n);
`default_nettype wire

// [tb/asp_remote.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// far-end serial device
// ----
module asp_remote #(parameter int BIT = 32) (
  input wire logic clock,
  input wire logic tx_pin,
  output var logic rx_pin,
  output var logic [8:0] got_word,
  output var logic [31:0] got_cnt
);
  int i;
  // line idles high
  initial rx_pin = 1'b1;
  // one frame, lsb first
  task automatic send(input logic [8:0] w, input int n, input logic stop);
    rx_pin <= 1'b0;
    repeat (BIT) @(posedge clock);
    for (int k = 0; k < n; k++) begin
      rx_pin <= w[k];
      repeat (BIT) @(posedge clock);
    end
    rx_pin <= stop;
    repeat (BIT) @(posedge clock);
    rx_pin <= 1'b1;
    repeat (BIT) @(posedge clock);
  endtask
  // capture 8 data bits and stop
  initial begin
    got_cnt = 0;
    got_word = 9'h000;
    forever begin
      @(negedge tx_pin);
      repeat (BIT / 2) @(posedge clock);
      for (i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clock);
        got_word[i] = tx_pin;
      end
      got_cnt++;
    end
  end
endmodule
`default_nettype wire

// [tb/test_asp_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_asp_top;
  // ----
  // signals
  // ----
  localparam int BIT = 32;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, oe_n, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, got_cnt;
  wire [8:0] got_word;
  logic [31:0] d;
  logic [1:0] rr;
  int bad_count = 0;
  int checks = 0;
  always #5 clock = ~clock;
  asp_top #(.TICK_DIV(16'h0002)) dut_u (.clock(clock), .reset(reset), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_pin_oe_n(oe_n), .irq(irq));
  asp_remote #(.BIT(BIT)) remote_u (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .got_word(got_word), .got_cnt(got_cnt));
  // ----
  // helpers
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // register write, halves released as taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  // register read into d and rr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  // poll status until a flag shows
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      rd(8'h00);
      n++;
    end while (d[b] !== 1'b1 && n < 300);
    cmp(d[b], 1'b1);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rd(8'h00);
    cmp(d, 32'hc0);
    rd(8'h0c);
    cmp(d, 32'h00);
    rd(8'h10);
    cmp(rr, 2'h2);
    wr(8'h10, 8'h00);
    cmp(rr, 2'h2);
    cmp(oe_n, 1'b1);
  endtask
  task automatic t_tx();
    int n;
    n = 0;
    wr(8'h0c, 8'h08);
    cmp(rr, 2'h0);
    rd(8'h04);
    wr(8'h04, 8'h11);
    repeat (12 * BIT) @(posedge clock);
    cmp(got_cnt, 0);
    cmp(oe_n, 1'b0);
    rd(8'h00);
    wr(8'h04, 8'ha5);
    rd(8'h00);
    cmp(d[6], 1'b0);
    while (got_cnt == 0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    cmp(got_word, 9'h1a5);
    wait_bit(6);
    wr(8'h0c, 8'h48);
    repeat (2) @(posedge clock);
    cmp(irq, 1'b1);
  endtask
  task automatic t_rx();
    wr(8'h0c, 8'h24);
    remote_u.send(9'h03c, 8, 1'b1);
    wait_bit(5);
    cmp(irq, 1'b1);
    rd(8'h04);
    cmp(d, 32'h3c);
    rd(8'h00);
    cmp(d, 32'hc0);
    remote_u.send(9'h055, 8, 1'b1);
    remote_u.send(9'h066, 8, 1'b1);
    rd(8'h00);
    cmp(d & 32'h28, 32'h28);
    rd(8'h04);
    cmp(d, 32'h55);
    wait_bit(4);
    rd(8'h04);
    // restart idle detection without a new word
    wr(8'h0c, 8'h20);
    wr(8'h0c, 8'h24);
    repeat (12 * BIT) @(posedge clock);
    rd(8'h00);
    cmp(d[4], 1'b0);
  endtask
  // address-mark wake from mute
  task automatic t_mute();
    wr(8'h08, 8'h08);
    wr(8'h0c, 8'h26);
    remote_u.send(9'h011, 8, 1'b1);
    rd(8'h00);
    cmp(d[5], 1'b0);
    remote_u.send(9'h091, 8, 1'b1);
    wait_bit(5);
    rd(8'h0c);
    cmp(d, 32'h24);
    rd(8'h04);
    cmp(d, 32'h91);
  endtask
  task automatic t_err();
    wr(8'h08, 8'h04);
    remote_u.send(9'h001, 8, 1'b1);
    wait_bit(0);
    rd(8'h04);
    // odd parity: same word now passes
    wr(8'h08, 8'h06);
    remote_u.send(9'h001, 8, 1'b1);
    wait_bit(5);
    cmp(d[0], 1'b0);
    rd(8'h04);
    remote_u.send(9'h000, 8, 1'b0);
    wait_bit(1);
    rd(8'h04);
    wr(8'h08, 8'h10);
    remote_u.send(9'h1aa, 9, 1'b1);
    wait_bit(5);
    rd(8'h08);
    cmp(d, 32'h90);
    rd(8'h04);
    cmp(d, 32'haa);
  endtask
  // verdict and stop
  task automatic end_sim();
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_tx();
    t_rx();
    t_mute();
    t_err();
    end_sim();
  end
  // hang guard
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
